//--- bench/mpi_core_sva.sv
// Port checker for the pump interface core
`timescale 1ns/10ps
module mpi_core_sva
   import mpi_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [2:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic host_wr,
   input wire logic ram_request,
   input wire logic originate_select,
   input wire logic pump_error,
   input wire logic soft_reset_request,
   input wire logic host_handshake_control,
   input wire logic [6:0] pump_mode,
   input wire logic pump_standby,
   input wire logic [15:0] dial_on_count
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // ------------------------------------------------------------
   // Busy time counter
   // ------------------------------------------------------------
   logic [11:0] busy_cnt;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busy_cnt <= 12'h000;
      end else if (ram_request) begin
         busy_cnt <= busy_cnt + 12'h001;
      end else begin
         busy_cnt <= 12'h000;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   standby_flag_a: assert property (
      pump_standby == (pump_mode == 7'h00)) else $error("standby flag wrong");
   handshake_mode_a: assert property (
      host_handshake_control |-> pump_mode inside {7'h08, 7'h09, 7'h0b})
      else $error("handshake outside V.22 modes");
   error_cause_a: assert property (
      $rose(pump_error) |-> !(pump_mode inside {7'h00, 7'h01, 7'h02, 7'h03, 7'h04,
      7'h08, 7'h09, 7'h0b, 7'h10, 7'h11, 7'h13, 7'h14})) else $error("error on valid mode");
   error_sticky_a: assert property (
      pump_error && !soft_reset_request |=> pump_error || soft_reset_request)
      else $error("error flag dropped");
   soft_reset_end_a: assert property (
      $rose(soft_reset_request) |-> ##[8:40] !soft_reset_request)
      else $error("soft reset never ends");
   reset_busy_a: assert property (
      soft_reset_request |-> ram_request) else $error("request low in soft reset");
   request_start_a: assert property (
      host_wr && host_addr == 3'h4 && host_wdata[1] && !ram_request |=> ram_request)
      else $error("request not taken");
   request_time_a: assert property (
      busy_cnt <= 12'h854) else $error("request too long");
   config_hold_a: assert property (
      !ram_request |=> $stable(pump_mode) && $stable(originate_select))
      else $error("config changed while idle");
   dial_hold_a: assert property (
      !ram_request |=> $stable(dial_on_count)) else $error("dial word changed while idle");

   cover property ($rose(soft_reset_request));
   cover property ($rose(pump_error));
   cover property ($rose(host_handshake_control));
endmodule

bind mpi_core mpi_core_sva mpi_core_sva_i (
   .clk(clk),
   .resetn(resetn),
   .host_addr(host_addr),
   .host_wdata(host_wdata),
   .host_wr(host_wr),
   .ram_request(ram_request),
   .originate_select(originate_select),
   .pump_error(pump_error),
   .soft_reset_request(soft_reset_request),
   .host_handshake_control(host_handshake_control),
   .pump_mode(pump_mode),
   .pump_standby(pump_standby),
   .dial_on_count(dial_on_count)
);

//--- bench/mpi_host_model.sv
// Host processor model using the indirect access registers
`timescale 1ns/10ps
`include "mpi_regs.svh"
module mpi_host_model (
   input wire logic clk,
   input wire logic [7:0] host_rdata,
   output logic [2:0] host_addr,
   output logic [7:0] host_wdata,
   output logic host_wr,
   output logic host_rd
);
   int poll_fail = 0;

   initial begin
      host_addr = 3'h0;
      host_wdata = 8'h00;
      host_wr = 1'b0;
      host_rd = 1'b0;
   end

   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      @(negedge clk);
      host_wr = 1'b0;
      host_wdata = ~d;
   endtask

   task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
      @(negedge clk);
      host_addr = a;
      host_rd = 1'b1;
      @(negedge clk);
      host_rd = 1'b0;
      @(negedge clk);
      d = host_rdata;
   endtask

   task automatic ram_op(input logic [8:0] a, input logic dir, input logic [15:0] d,
         output logic [15:0] q);
      logic [7:0] r;
      int n;
      q = 16'h0000;
      n = 0;
      if (dir) begin
         reg_wr(`MPI_HOST_DATA_LOW, d[7:0]);
         reg_wr(`MPI_HOST_DATA_HIGH, d[15:8]);
      end
      reg_wr(`MPI_HOST_ADDR_LOW, a[7:0]);
      reg_wr(`MPI_HOST_REQUEST, {5'h00, dir, 1'b1, a[8]});
      r = 8'h02;
      while (r[1] !== 1'b0 && n < 1500) begin
         reg_rd(`MPI_HOST_REQUEST, r);
         n++;
      end
      if (r[1] !== 1'b0) begin
         poll_fail++;
         $display("Error at %0t: request never cleared", $time);
      end
      if (!dir) begin
         reg_rd(`MPI_HOST_DATA_LOW, r);
         q[7:0] = r;
         reg_rd(`MPI_HOST_DATA_HIGH, r);
         q[15:8] = r;
      end
   endtask
endmodule

//--- bench/tb.sv
// Self-checking bench for the pump interface core
`timescale 1ns/10ps
`include "mpi_regs.svh"
module tb;
   import mpi_pkg::*;
   logic clk, resetn, host_wr, host_rd, ram_request, originate_select, pump_error;
   logic soft_reset_request, host_handshake_control, pump_standby;
   logic [2:0] host_addr;
   logic [7:0] host_wdata, host_rdata;
   logic [6:0] pump_mode;
   logic [15:0] dial_on_count, dial_off_count, dial_interpulse_count;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;

   mpi_core mpi_core_i (.clk(clk), .resetn(resetn), .host_addr(host_addr),
      .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
      .host_rdata(host_rdata), .ram_request(ram_request),
      .originate_select(originate_select), .pump_error(pump_error),
      .soft_reset_request(soft_reset_request),
      .host_handshake_control(host_handshake_control), .pump_mode(pump_mode),
      .pump_standby(pump_standby), .dial_on_count(dial_on_count),
      .dial_off_count(dial_off_count), .dial_interpulse_count(dial_interpulse_count));
   mpi_host_model mpi_host_model_i (.clk(clk), .host_rdata(host_rdata),
      .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
      .host_rd(host_rd));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      error_cnt += mpi_host_model_i.poll_fail;
      $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   task automatic t_dial();
      logic [15:0] q;
      mpi_host_model_i.ram_op(`MPI_W_DIAL_ON, 1'b1, 16'h1234, q);
      mpi_host_model_i.ram_op(`MPI_W_DIAL_OFF, 1'b1, 16'h5a0f, q);
      mpi_host_model_i.ram_op(`MPI_W_DIAL_INTERPULSE, 1'b1, 16'hfedc, q);
      check(dial_on_count, 16'h1234);
      check(dial_off_count, 16'h5a0f);
      check(dial_interpulse_count, 16'hfedc);
      mpi_host_model_i.ram_op(`MPI_W_DIAL_OFF, 1'b0, 16'h0000, q);
      check(q, 16'h5a0f);
      $display("Test dial words done");
   endtask

   task automatic t_abort();
      logic [7:0] r;
      mpi_host_model_i.reg_wr(`MPI_HOST_DATA_LOW, 8'h77);
      mpi_host_model_i.reg_wr(`MPI_HOST_ADDR_LOW, 8'h8d);
      mpi_host_model_i.reg_wr(`MPI_HOST_REQUEST, 8'h07);
      mpi_host_model_i.reg_wr(`MPI_HOST_DATA_LOW, 8'h11);
      mpi_host_model_i.reg_wr(`MPI_HOST_REQUEST, 8'h00);
      check(ram_request, 1'b0);
      check(dial_off_count, 16'h5a0f);
      mpi_host_model_i.reg_rd(`MPI_HOST_DATA_LOW, r);
      check(r, 8'h77);
      $display("Test abort done");
   endtask

   task automatic t_config();
      logic [15:0] w [5] = '{16'h4408, 16'h0409, 16'h440b, 16'h0401, 16'h4400};
      logic [15:0] q;
      for (int i = 0; i < 5; i++) begin
         // role and mode in one write, unused bits zero
         mpi_host_model_i.ram_op(`MPI_W_CONFIG, 1'b1, w[i], q);
         check(originate_select, w[i][14]);
         check(host_handshake_control, w[i][10] && i < 3);
         check(pump_standby, w[i][6:0] == 7'h00);
         check(pump_mode, w[i][6:0]);
         mpi_host_model_i.ram_op(`MPI_W_CONFIG, 1'b0, 16'h0000, q);
         check(q, w[i]);
      end
      $display("Test config word done");
   endtask

   task automatic t_error();
      logic [15:0] q;
      mpi_host_model_i.ram_op(`MPI_W_CONFIG, 1'b1, 16'h0005, q);
      check(pump_error, 1'b1);
      mpi_host_model_i.ram_op(`MPI_W_CONFIG, 1'b1, 16'h4008, q);
      check(pump_error, 1'b1);
      mpi_host_model_i.ram_op(`MPI_W_CONFIG, 1'b0, 16'h0000, q);
      check(q, 16'h6008);
      // host resets the pump after an error
      mpi_host_model_i.ram_op(`MPI_W_CONFIG, 1'b1, 16'h0100, q);
      check(soft_reset_request, 1'b0);
      check(pump_error, 1'b0);
      check(pump_standby, 1'b1);
      check(dial_on_count, 16'h1234);
      mpi_host_model_i.ram_op(`MPI_W_CONFIG, 1'b0, 16'h0000, q);
      check(q, 16'h0000);
      $display("Test error and soft reset done");
   endtask

   task automatic t_hard_reset();
      logic [15:0] q;
      mpi_host_model_i.ram_op(`MPI_W_CONFIG, 1'b1, 16'h4005, q);
      check(pump_error, 1'b1);
      @(negedge clk);
      resetn = 1'b0;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      check(pump_error, 1'b0);
      check(originate_select, 1'b0);
      check(pump_standby, 1'b1);
      check(dial_on_count, 16'h0000);
      mpi_host_model_i.ram_op(`MPI_W_DIAL_OFF, 1'b0, 16'h0000, q);
      check(q, 16'h0000);
      $display("Test hard reset done");
   endtask

   initial begin
      resetn = 1'b0;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      check(pump_standby, 1'b1);
      check(ram_request, 1'b0);
      t_dial();
      t_abort();
      t_config();
      t_error();
      t_hard_reset();
      report_and_stop();
   end
endmodule

//--- pkg/mpi_pkg.sv
// Types shared by the pump interface modules
package mpi_pkg;

   typedef enum logic [2:0] {
      MPI_IDLE = 3'b000,
      MPI_WAIT = 3'b001,
      MPI_ACCESS = 3'b010,
      MPI_READ_DONE = 3'b011,
      MPI_SOFT_RESET = 3'b100
   } mpi_state_e;

   typedef struct packed {
      mpi_state_e state;
      logic [11:0] count;
      logic [7:0] addr_low;
      logic addr_high;
      logic direction;
      logic request;
      logic [7:0] data_low;
      logic [7:0] data_high;
      logic [7:0] host_rdata;
      logic [6:0] mode;
      logic originate;
      logic handshake_bit;
      logic soft_reset;
      logic error;
      logic handshake_active;
      logic standby;
      logic [15:0] dial_on;
      logic [15:0] dial_off;
      logic [15:0] dial_interpulse;
   } mpi_core_s;

   // Mode codes the pump understands; anything else is an error
   function automatic logic mpi_mode_valid(input logic [6:0] m);
      logic ok;
      ok = 1'b0;
      unique case (m)
         7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h08, 7'h09, 7'h0b,
         7'h10, 7'h11, 7'h13, 7'h14: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

endpackage

//--- pkg/mpi_regs.svh
// Offsets, field positions, reset values and timing counts of the pump interface
`ifndef MPI_REGS_SVH
`define MPI_REGS_SVH

// ------------------------------------------------------------
// Host-side indirect access registers (3-bit host address)
// ------------------------------------------------------------
`define MPI_HOST_DATA_LOW 3'h0
`define MPI_HOST_DATA_HIGH 3'h1
`define MPI_HOST_ADDR_LOW 3'h2
`define MPI_HOST_REQUEST 3'h4

// Fields of the request register
`define MPI_REQ_ADDR_HIGH 0
`define MPI_REQ_REQUEST 1
`define MPI_REQ_DIRECTION 2

// ------------------------------------------------------------
// Interface RAM word map (9-bit word address)
// ------------------------------------------------------------
`define MPI_W_TONE_DET_STATUS 9'h000
`define MPI_W_TONE_DET_THRESH 9'h003
`define MPI_W_TONE_DET_LEVELS 9'h026
`define MPI_W_FILTER_ON_POINT 9'h051
`define MPI_W_FILTER_OFF_POINT 9'h052
`define MPI_W_EYE_QUALITY 9'h092
`define MPI_W_TONE_DET_COEF 9'h145
`define MPI_W_FILTER_A_COEF 9'h155
`define MPI_W_FILTER_B_COEF 9'h15f
`define MPI_W_TX_LEVEL 9'h185
`define MPI_W_DIAL_ON 9'h18c
`define MPI_W_DIAL_OFF 9'h18d
`define MPI_W_DIAL_INTERPULSE 9'h18e
`define MPI_W_TONE_GEN_A 9'h191
`define MPI_W_TONE_GEN_B 9'h196
`define MPI_W_DUAL_TONE_LOW 9'h1a0
`define MPI_W_DUAL_TONE_HIGH 9'h1a1
`define MPI_W_BAND_REJECT 9'h1a2
`define MPI_W_CONN_SPEED 9'h1f0
`define MPI_W_CARRIER_ON 9'h1f4
`define MPI_W_CARRIER_OFF 9'h1f5
`define MPI_W_MSE_MAX 9'h1f6
`define MPI_W_MODEM_STATUS 9'h1f7
`define MPI_W_MISC_CONTROLS 9'h1fa
`define MPI_W_TONE_STATUS 9'h1fc
`define MPI_W_BUFFER_CONTROL 9'h1fd
`define MPI_W_TRAINING_CONTROL 9'h1fe
`define MPI_W_CONFIG 9'h1ff

// ------------------------------------------------------------
// Configuration word fields and reset values
// ------------------------------------------------------------
`define MPI_CFG_ORIGINATE 14
`define MPI_CFG_ERROR 13
`define MPI_CFG_HANDSHAKE 10
`define MPI_CFG_SOFT_RESET 8
`define MPI_CFG_MODE_MSB 6
`define MPI_MODE_STANDBY 7'h00
`define MPI_MODE_V22BIS 7'h08
`define MPI_MODE_V22 7'h09
`define MPI_MODE_B1200 7'h0b

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define MPI_CLK_MHZ 20
`define MPI_RAM_ACCESS_US 105
`define MPI_RAM_ACCESS_CYCLES (`MPI_RAM_ACCESS_US * `MPI_CLK_MHZ)
`define MPI_SOFT_RESET_CYCLES 16

`endif

//--- src/mpi_core.sv
// Modem pump interface RAM with indirect host access and configuration word
//
// Function
// RL1: Configuration bit 14 high selects originate role, low selects answer role.
// RL2: Host sets originate select no later than the write loading the mode field.
// RL3: Device raises configuration bit 13 on an internal error such as bad mode.
// RL4: Host should reset the pump after seeing the error flag.
// RL5: Host writes bit 8 to soft reset; device clears it when reset completes.
// RL6: Bit 10 hands the host manual handshake control in V.22 family modes.
// RL7: Host writes zero to bits 15 and 7; bits 12, 11, 9 reserved.
// RL8: Device holds dial on, off and inter-pulse count words at 18C-18E.
// RL9: Host loads address, then one request write, then waits for request clear.
// RL10: A RAM request completes and clears its request bit within 105 us; a soft reset write keeps it set 2115 cycles, past 105 us at 20 MHz.
// RL11: Mode zero selects idle standby; other codes select tone, dial, modem modes.
// RL12: Error flag stays set until a hard or soft reset clears it.
`timescale 1ns/10ps
`include "mpi_regs.svh"
module mpi_core
   import mpi_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [2:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic host_wr,
   input wire logic host_rd,
   output logic [7:0] host_rdata,
   output logic ram_request,
   output logic originate_select,
   output logic pump_error,
   output logic soft_reset_request,
   output logic host_handshake_control,
   output logic [6:0] pump_mode,
   output logic pump_standby,
   output logic [15:0] dial_on_count,
   output logic [15:0] dial_off_count,
   output logic [15:0] dial_interpulse_count
);

   // ------------------------------------------------------------
   // Constants
   // ------------------------------------------------------------
   // Idle, access and read-done cycles are spent outside the wait
   localparam logic [11:0] WAIT_LOAD = 12'(`MPI_RAM_ACCESS_CYCLES - 4);
   localparam logic [11:0] SRST_LOAD = 12'(`MPI_SOFT_RESET_CYCLES - 1);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   mpi_core_s s;
   mpi_core_s next_s;

   logic [8:0] ram_addr;
   logic [15:0] ram_wdata;
   logic ram_we;
   logic ram_rd;
   logic [15:0] ram_rdata;
   logic [15:0] config_word;
   logic done;
   logic [15:0] wword;

   // ------------------------------------------------------------
   // Interface RAM
   // ------------------------------------------------------------
   mpi_ram u_ram (
      .clk(clk),
      .resetn(resetn),
      .addr(ram_addr),
      .wdata(ram_wdata),
      .we(ram_we),
      .rd(ram_rd),
      .rdata(ram_rdata)
   );

   // ------------------------------------------------------------
   // Configuration word as seen by reads
   // ------------------------------------------------------------
   always_comb begin
      config_word = 16'h0000;
      // RL1 role select
      config_word[`MPI_CFG_ORIGINATE] = s.originate;
      // RL3 error flag
      config_word[`MPI_CFG_ERROR] = s.error;
      config_word[`MPI_CFG_HANDSHAKE] = s.handshake_bit;
      // RL5 soft reset status
      config_word[`MPI_CFG_SOFT_RESET] = s.soft_reset;
      config_word[`MPI_CFG_MODE_MSB:0] = s.mode;
   end

   assign ram_addr = {s.addr_high, s.addr_low};
   assign ram_wdata = {s.data_high, s.data_low};
   assign wword = ram_wdata;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      ram_we = 1'b0;
      ram_rd = 1'b0;
      done = 1'b0;

      // Access engine
      unique case (s.state)
         MPI_IDLE: begin
            if (s.request) begin
               next_s.count = WAIT_LOAD;
               next_s.state = MPI_WAIT;
            end
         end
         MPI_WAIT: begin
            if (s.count == 12'h000) begin
               next_s.state = MPI_ACCESS;
            end else begin
               next_s.count = s.count - 12'h001;
            end
         end
         MPI_ACCESS: begin
            if (s.direction) begin
               ram_we = (ram_addr != `MPI_W_CONFIG);
               next_s.state = MPI_IDLE;
               done = 1'b1;
               // RL8 dial timer words
               if (ram_addr == `MPI_W_DIAL_ON) begin
                  next_s.dial_on = wword;
               end
               if (ram_addr == `MPI_W_DIAL_OFF) begin
                  next_s.dial_off = wword;
               end
               if (ram_addr == `MPI_W_DIAL_INTERPULSE) begin
                  next_s.dial_interpulse = wword;
               end
               if (ram_addr == `MPI_W_CONFIG) begin
                  if (wword[`MPI_CFG_SOFT_RESET]) begin
                     // RL5 start soft reset
                     next_s.soft_reset = 1'b1;
                     next_s.count = SRST_LOAD;
                     next_s.state = MPI_SOFT_RESET;
                     done = 1'b0;
                  end else begin
                     // RL1 role taken with mode
                     next_s.originate = wword[`MPI_CFG_ORIGINATE];
                     next_s.handshake_bit = wword[`MPI_CFG_HANDSHAKE];
                     // RL11 operating mode
                     next_s.mode = wword[`MPI_CFG_MODE_MSB:0];
                     // RL3 bad mode sets error
                     if (!mpi_mode_valid(wword[`MPI_CFG_MODE_MSB:0])) begin
                        next_s.error = 1'b1;
                     end
                  end
               end
            end else begin
               ram_rd = 1'b1;
               next_s.state = MPI_READ_DONE;
            end
         end
         MPI_READ_DONE: begin
            if (ram_addr == `MPI_W_CONFIG) begin
               next_s.data_low = config_word[7:0];
               next_s.data_high = config_word[15:8];
            end else begin
               next_s.data_low = ram_rdata[7:0];
               next_s.data_high = ram_rdata[15:8];
            end
            next_s.state = MPI_IDLE;
            done = 1'b1;
         end
         MPI_SOFT_RESET: begin
            if (s.count == 12'h000) begin
               // RL5 self clearing soft reset
               next_s.soft_reset = 1'b0;
               next_s.mode = `MPI_MODE_STANDBY;
               next_s.originate = 1'b0;
               next_s.handshake_bit = 1'b0;
               // RL12 error cleared only here and by hard reset
               next_s.error = 1'b0;
               next_s.state = MPI_IDLE;
               done = 1'b1;
            end else begin
               next_s.count = s.count - 12'h001;
            end
         end
         default: begin
            // Unused state codes fall back to idle
            next_s.state = MPI_IDLE;
         end
      endcase

      // RL10 request clears on completion
      if (done) begin
         next_s.request = 1'b0;
      end

      // Host register writes
      if (host_wr) begin
         unique case (host_addr)
            `MPI_HOST_DATA_LOW: begin
               if (!s.request) begin
                  next_s.data_low = host_wdata;
               end
            end
            `MPI_HOST_DATA_HIGH: begin
               if (!s.request) begin
                  next_s.data_high = host_wdata;
               end
            end
            `MPI_HOST_ADDR_LOW: begin
               if (!s.request) begin
                  next_s.addr_low = host_wdata;
               end
            end
            `MPI_HOST_REQUEST: begin
               // RL9 one write starts an access
               if (!s.request || done) begin
                  next_s.addr_high = host_wdata[`MPI_REQ_ADDR_HIGH];
                  next_s.direction = host_wdata[`MPI_REQ_DIRECTION];
                  next_s.request = host_wdata[`MPI_REQ_REQUEST];
               end else if (!host_wdata[`MPI_REQ_REQUEST] &&
                            s.state != MPI_SOFT_RESET) begin
                  // Clearing the request aborts a pending access, but not a soft reset in progress
                  next_s.request = 1'b0;
                  next_s.state = MPI_IDLE;
               end
            end
            default: begin
            end
         endcase
      end

      // Host register reads, registered
      if (host_rd) begin
         unique case (host_addr)
            `MPI_HOST_DATA_LOW: next_s.host_rdata = s.data_low;
            `MPI_HOST_DATA_HIGH: next_s.host_rdata = s.data_high;
            `MPI_HOST_ADDR_LOW: next_s.host_rdata = s.addr_low;
            `MPI_HOST_REQUEST: begin
               next_s.host_rdata = 8'h00;
               next_s.host_rdata[`MPI_REQ_ADDR_HIGH] = s.addr_high;
               next_s.host_rdata[`MPI_REQ_REQUEST] = s.request;
               next_s.host_rdata[`MPI_REQ_DIRECTION] = s.direction;
            end
            default: next_s.host_rdata = 8'h00;
         endcase
      end

      // RL6 manual handshake in V.22 family
      next_s.handshake_active = next_s.handshake_bit &&
         (next_s.mode == `MPI_MODE_V22BIS || next_s.mode == `MPI_MODE_V22 ||
          next_s.mode == `MPI_MODE_B1200);
      // RL11 mode zero is standby
      next_s.standby = (next_s.mode == `MPI_MODE_STANDBY);
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.state <= MPI_IDLE;
         s.standby <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign host_rdata = s.host_rdata;
   assign ram_request = s.request;
   assign originate_select = s.originate;
   assign pump_error = s.error;
   assign soft_reset_request = s.soft_reset;
   assign host_handshake_control = s.handshake_active;
   assign pump_mode = s.mode;
   assign pump_standby = s.standby;
   assign dial_on_count = s.dial_on;
   assign dial_off_count = s.dial_off;
   assign dial_interpulse_count = s.dial_interpulse;

endmodule

//--- src/mpi_ram.sv
// Interface RAM of 512 words with registered read data
`timescale 1ns/10ps
module mpi_ram
   import mpi_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [8:0] addr,
   input wire logic [15:0] wdata,
   input wire logic we,
   input wire logic rd,
   output logic [15:0] rdata
);

   typedef struct packed {
      logic [511:0][15:0] mem;
      logic [15:0] rdata;
   } mpi_ram_s;

   mpi_ram_s s;
   mpi_ram_s next_s;

   always_comb begin
      next_s = s;
      if (we) begin
         next_s.mem[addr] = wdata;
      end
      if (rd) begin
         next_s.rdata = s.mem[addr];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;

endmodule
